// file: shared/syscon_pkg.sv
package syscon_pkg;
    // ==========================================
    // Reset values of outputs
    localparam logic PROGRAM_N_RESET = 1'b0;
    localparam logic POR_N_RESET = 1'b0;
    localparam logic POWER_GOOD_RESET = 1'b0;
    localparam logic DCDC_ENABLE_RESET = 1'b0;
    localparam logic JTAG_SELECT_RESET = 1'b0;
    localparam logic GREEN_RESET = 1'b0;
    localparam logic RED_RESET = 1'b1;
    // ==========================================
    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
    // ==========================================
    // Timing: rail settle time after rails stable
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int RAIL_SETTLE_US = 10;
    localparam int RAIL_SETTLE_CYCLES = (RAIL_SETTLE_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SETTLE_COUNT_W = 12;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_RAILS_OFF,
        ST_SETTLE,
        ST_RUN
    } seq_state_t;
endpackage

// file: shared/sync_if.sv
`timescale 1ns/1ps
// ==========================================
// Raw and synchronised baseboard inputs
interface sync_if;
    logic [2:0] raw;
    logic [2:0] synced;
    modport source (output raw, input synced);
    modport sink (input raw, output synced);
endinterface

// file: hdl/input_sync.sv
`timescale 1ns/1ps
// ==========================================
// Two-stage synchroniser bank
module input_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clock,
    input wire logic nrst,
    sync_if.sink port
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Refuse an empty bank at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("input_sync: WIDTH must be at least 1");
    end

    // First stage read only by second stage
    // two-flop synchronising
    always_comb begin
        meta_next = port.raw;
        sync_next = meta_reg;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign port.synced = sync_reg;
endmodule

// file: hdl/system_controller.sv
`timescale 1ns/1ps
// Overview of operation
// - Power good low if disabled or invalid
// - Select low routes JTAG to FPGA
// - Enable low pulls power-on reset low
// - Program line low until rails stable
// - External reset low resets the FPGA
// - Enable low also resets the FPGA
// - Enable low leaves converters running
// - Two indicators, user owned after configuration
module system_controller #(
    parameter int SETTLE_CYCLES = syscon_pkg::RAIL_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic power_enable_in,
    input wire logic external_reset_n,
    input wire logic jtag_target_select,
    input wire logic supply_valid,
    input wire logic rails_stable,
    input wire logic fpga_config_done,
    input wire logic user_green,
    input wire logic user_red,
    output logic power_good_out,
    output logic dcdc_enable,
    output logic fpga_program_n,
    output logic fpga_por_n,
    output logic jtag_to_fpga,
    output logic jtag_to_controller,
    output logic green_indicator,
    output logic red_indicator
);
    localparam logic [syscon_pkg::SETTLE_COUNT_W-1:0] SETTLE_LAST =
        syscon_pkg::SETTLE_COUNT_W'(SETTLE_CYCLES - 1);

    // Settle count must fit the counter width
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > (1 << syscon_pkg::SETTLE_COUNT_W)) begin : g_bad_settle
        $error("system_controller: SETTLE_CYCLES out of range");
    end

    // ==========================================
    // Input synchronisation
    sync_if sio ();
    logic enable_s;
    logic ext_reset_n_s;
    logic jtag_sel_s;

    assign sio.raw = {jtag_target_select, external_reset_n, power_enable_in};
    // Enable and reset pins idle high; select starts at the FPGA route
    input_sync #(
        .WIDTH(3),
        .INIT(3'h3)
    ) u_sync (
        .clock(clock),
        .nrst(nrst),
        .port(sio.sink)
    );
    assign enable_s = sio.synced[0];
    assign ext_reset_n_s = sio.synced[1];
    assign jtag_sel_s = sio.synced[2];

    // ==========================================
    // Rail sequencer
    syscon_pkg::seq_state_t state_reg;
    syscon_pkg::seq_state_t state_next;
    logic [syscon_pkg::SETTLE_COUNT_W-1:0] count_reg;
    logic [syscon_pkg::SETTLE_COUNT_W-1:0] count_next;

    // Waits for supply valid, rails stable and a settle time
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            syscon_pkg::ST_RAILS_OFF: begin
                count_next = '0;
                if (supply_valid) begin
                    state_next = syscon_pkg::ST_SETTLE;
                end
            end
            syscon_pkg::ST_SETTLE: begin
                if (!supply_valid) begin
                    state_next = syscon_pkg::ST_RAILS_OFF;
                end else if (rails_stable && count_reg == SETTLE_LAST) begin
                    state_next = syscon_pkg::ST_RUN;
                end else if (rails_stable) begin
                    count_next = count_reg + 1'b1;
                end else begin
                    count_next = '0;
                end
            end
            syscon_pkg::ST_RUN: begin
                if (!supply_valid || !rails_stable) begin
                    state_next = syscon_pkg::ST_RAILS_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= syscon_pkg::ST_RAILS_OFF;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // ==========================================
    // Output registers
    logic rails_up;
    logic power_good_reg;
    logic power_good_next;
    logic dcdc_reg;
    logic dcdc_next;
    logic prog_n_reg;
    logic prog_n_next;
    logic por_n_reg;
    logic por_n_next;
    logic green_reg;
    logic green_next;
    logic red_reg;
    logic red_next;
    logic jsel_reg;
    logic jsel_next;

    assign rails_up = (state_reg == syscon_pkg::ST_RUN);

    // Outputs computed from synchronised pins, sequencer and the raw supply valid, config done and user inputs
    always_comb begin
        power_good_next = enable_s && rails_up;
        dcdc_next = supply_valid;
        prog_n_next = rails_up && ext_reset_n_s && enable_s;
        por_n_next = enable_s && rails_up;
        jsel_next = jtag_sel_s;
        if (fpga_config_done && prog_n_reg) begin
            green_next = user_green;
            red_next = user_red;
        end else begin
            // Red shows FPGA unconfigured or held by controller; green shows rails up
            green_next = rails_up;
            red_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            power_good_reg <= syscon_pkg::POWER_GOOD_RESET;
            dcdc_reg <= syscon_pkg::DCDC_ENABLE_RESET;
            prog_n_reg <= syscon_pkg::PROGRAM_N_RESET;
            por_n_reg <= syscon_pkg::POR_N_RESET;
            jsel_reg <= syscon_pkg::JTAG_SELECT_RESET;
            green_reg <= syscon_pkg::GREEN_RESET;
            red_reg <= syscon_pkg::RED_RESET;
        end else begin
            power_good_reg <= power_good_next;
            dcdc_reg <= dcdc_next;
            prog_n_reg <= prog_n_next;
            por_n_reg <= por_n_next;
            jsel_reg <= jsel_next;
            green_reg <= green_next;
            red_reg <= red_next;
        end
    end

    assign power_good_out = power_good_reg;
    assign dcdc_enable = dcdc_reg;
    assign fpga_program_n = prog_n_reg;
    assign fpga_por_n = por_n_reg;
    assign jtag_to_fpga = !jsel_reg;
    assign jtag_to_controller = jsel_reg;
    assign green_indicator = green_reg;
    assign red_indicator = red_reg;

    // ==========================================
    // Assertions
    a_power_good_follows: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> power_good_out == ($past(enable_s) && $past(rails_up)))
        else $error("power good does not follow enable and rails");
    a_jtag_route: assert property (@(posedge clock) disable iff (!nrst)
        !jtag_sel_s |=> jtag_to_fpga && !jtag_to_controller)
        else $error("jtag select low not routed to fpga");
    a_jtag_select: assert property (@(posedge clock) disable iff (!nrst)
        jtag_sel_s |=> jtag_to_controller)
        else $error("jtag select high not routed to controller");
    a_por_on_enable: assert property (@(posedge clock) disable iff (!nrst)
        !enable_s |=> !fpga_por_n)
        else $error("por not pulled on enable low");
    a_prog_hold: assert property (@(posedge clock) disable iff (!nrst)
        !rails_up |=> !fpga_program_n)
        else $error("program released before rails stable");
    a_settle_time: assert property (@(posedge clock) disable iff (!nrst)
        $rose(rails_up) |-> $past(state_reg) == syscon_pkg::ST_SETTLE && $past(count_reg) == SETTLE_LAST)
        else $error("rails declared up without settle time");
    a_ext_reset: assert property (@(posedge clock) disable iff (!nrst)
        !external_reset_n ##1 !external_reset_n ##1 !external_reset_n |=> !fpga_program_n)
        else $error("external reset did not reset fpga");
    a_enable_reset: assert property (@(posedge clock) disable iff (!nrst)
        !enable_s |=> !fpga_program_n)
        else $error("enable low did not reset fpga");
    a_dcdc_stays: assert property (@(posedge clock) disable iff (!nrst)
        supply_valid && $fell(enable_s) |=> dcdc_enable)
        else $error("converters switched off by enable");
    a_led_user: assert property (@(posedge clock) disable iff (!nrst)
        fpga_config_done && fpga_program_n |=> green_indicator == $past(user_green))
        else $error("green indicator not handed to user");
    c_power_up: cover property (@(posedge clock) disable iff (!nrst) $rose(power_good_out));
    c_ext_reset: cover property (@(posedge clock) disable iff (!nrst) rails_up && $fell(ext_reset_n_s));
    c_enable_por: cover property (@(posedge clock) disable iff (!nrst) rails_up && $fell(fpga_por_n));
    c_user_led: cover property (@(posedge clock) disable iff (!nrst) fpga_config_done && fpga_program_n);
endmodule

// file: dv/fpga_cfg_model.sv
`timescale 1ns/1ps
// ==========================================
// FPGA configuration load model
module fpga_cfg_model #(
    parameter int CFG_CYCLES = 30
) (
    input wire logic clock,
    input wire logic fpga_program_n,
    input wire logic flash_quad_enable_bit,
    output logic fpga_config_done
);
    int cnt_reg = 0;
    logic done_reg = 1'b0;
    assign fpga_config_done = done_reg;
    // Load restarts whenever the program line is pulled low
    // load needs quad bit
    always_ff @(posedge clock) begin
        if (!fpga_program_n) begin
            cnt_reg <= 0;
            done_reg <= 1'b0;
        end else if (cnt_reg < CFG_CYCLES) begin
            cnt_reg <= cnt_reg + 1;
        end else begin
            done_reg <= flash_quad_enable_bit;
        end
    end
endmodule

// file: dv/tb_system_controller.sv
`timescale 1ns/1ps
module tb_system_controller;
    typedef struct packed {logic [7:0] val; logic [7:0] mask;} note_t;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic power_enable_in = 1'b1;
    logic external_reset_n = 1'b1;
    logic jtag_target_select = 1'b0;
    logic supply_valid = 1'b0;
    logic rails_stable = 1'b0;
    logic user_green = 1'b1;
    logic user_red = 1'b1;
    logic fpga_config_done;
    logic [7:0] outs;
    note_t notes[$];
    note_t nt;
    event got;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // ==========================================
    // Design and far side
    system_controller #(.SETTLE_CYCLES(2)) dut_u (.clock(clock), .nrst(nrst),
        .power_enable_in(power_enable_in), .external_reset_n(external_reset_n),
        .jtag_target_select(jtag_target_select), .supply_valid(supply_valid), .rails_stable(rails_stable),
        .fpga_config_done(fpga_config_done), .user_green(user_green), .user_red(user_red),
        .power_good_out(outs[7]), .dcdc_enable(outs[6]), .fpga_program_n(outs[5]), .fpga_por_n(outs[4]),
        .jtag_to_fpga(outs[3]), .jtag_to_controller(outs[2]), .green_indicator(outs[1]), .red_indicator(outs[0]));
    fpga_cfg_model #(.CFG_CYCLES(30)) cfg_u (.clock(clock), .fpga_program_n(outs[5]),
        .flash_quad_enable_bit(1'b1), .fpga_config_done(fpga_config_done));
    // ==========================================
    // Clock and hang guard; 3000 cycles is far beyond the sequence
    initial forever #50 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t outputs %b expected %b", $time, seen, exp);
        end
    endtask
    // Note an expectation, then release the watcher n falling edges later
    task automatic expect_in(int n, logic [7:0] val, logic [7:0] mask);
        notes.push_back('{val, mask});
        repeat (n) @(negedge clock);
        -> got;
    endtask
    task automatic test_end(string s);
        $display("test %s done", s);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watcher takes the oldest note on every result
    initial forever begin
        @(got);
        nt = notes.pop_front();
        check(outs & nt.mask, nt.val & nt.mask);
    end
    // ==========================================
    // Main sequence, inputs change on falling edges
    initial begin
        void'($urandom(54946));
        expect_in(4, 8'h09, 8'hFF);
        nrst = 1'b1;
        test_end("reset");
        supply_valid = 1'b1;
        expect_in(10, 8'h49, 8'hFD);
        rails_stable = 1'b1;
        expect_in(1, 8'h49, 8'hFD);
        rails_stable = 1'b0;
        expect_in(4, 8'h49, 8'hFD);
        rails_stable = 1'b1;
        expect_in(1, 8'h49, 8'hFD);
        expect_in(8, 8'hFB, 8'hFF);
        test_end("power up");
        for (int i = 0; i < 60 && fpga_config_done !== 1'b1; i++) @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            {user_green, user_red} = 2'($urandom);
            expect_in(1, {6'b111110, user_green, user_red}, 8'hFF);
        end
        test_end("indicators");
        wait (outs[7] === 1'b1);
        for (int i = 0; i < 5; i++) begin
            jtag_target_select = (i == 4) ? 1'b0 : 1'($urandom);
            expect_in(3, {4'hF, ~jtag_target_select, jtag_target_select, 2'b00}, 8'hFC);
        end
        test_end("jtag");
        external_reset_n = 1'b0;
        expect_in(3, 8'h00, 8'h20);
        external_reset_n = 1'b1;
        expect_in(8, 8'hF0, 8'hF0);
        test_end("external reset");
        power_enable_in = 1'b0;
        expect_in(2, 8'hF0, 8'hF0);
        expect_in(1, 8'h40, 8'hF0);
        power_enable_in = 1'b1;
        expect_in(8, 8'hF0, 8'hF0);
        test_end("enable");
        supply_valid = 1'b0;
        expect_in(3, 8'h00, 8'hC0);
        test_end("supply loss");
        end_sim();
    end
endmodule
